// File: core/rtcca_map.svh
`ifndef RTCCA_MAP_SVH
`define RTCCA_MAP_SVH

// Register addresses of the calendar and alarm block.
`define RTCCA_ADDR_WEEKDAY 8'h07
`define RTCCA_ADDR_MONTH 8'h08
`define RTCCA_ADDR_YEAR 8'h09
`define RTCCA_ADDR_ALM_SEC 8'h0A
`define RTCCA_ADDR_ALM_MIN 8'h0B
`define RTCCA_ADDR_ALM_HOUR 8'h0C
`define RTCCA_ADDR_ALM_DAY 8'h0D
`define RTCCA_ADDR_ALM_WKDAY 8'h0E

// Field positions.
`define RTCCA_ALM_DIS_BIT 7
`define RTCCA_WKDAY_MSB 2
`define RTCCA_MONTH_MSB 4

// Reset values.
`define RTCCA_RST_WEEKDAY 3'h0
`define RTCCA_RST_MONTH 5'h01
`define RTCCA_RST_YEAR 8'h00
`define RTCCA_RST_ALARM 8'h80

// Calendar limits in BCD.
`define RTCCA_WKDAY_LAST 3'h6
`define RTCCA_MONTH_LAST 5'h12
`define RTCCA_MONTH_FEB 5'h02
`define RTCCA_YEAR_LAST 8'h99

// Number of alarm fields compared.
`define RTCCA_NUM_FIELDS 5

`endif

// File: core/rtcca_pkg.sv
package rtcca_pkg;
    typedef logic [7:0] rtcca_byte_t;
    typedef logic [3:0] rtcca_digit_t;
endpackage

// File: core/rtcca_core.sv
`timescale 1ns/1ps
`include "rtcca_map.svh"
module rtcca_core (
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    input wire logic I_CE,
    input wire logic I_TICK_1HZ,
    input wire logic I_ACCESS_BUSY,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_RD,
    input wire logic [6:0] I_SECONDS,
    input wire logic [6:0] I_MINUTES,
    input wire logic [5:0] I_HOURS,
    input wire logic I_HOUR_12H,
    input wire logic [5:0] I_DAYS,
    input wire logic I_DAY_STEP,
    input wire logic I_DAY_WRAP,
    input wire logic I_FLAG_CLEAR,
    output logic O_TIME_STEP,
    output logic [7:0] O_REG_RDATA,
    output logic [2:0] O_WEEKDAY,
    output logic [4:0] O_MONTH,
    output logic [7:0] O_YEAR,
    output logic [5:0] O_MONTH_LAST_DAY,
    output logic O_ALARM_FLAG
);

    logic [2:0] weekday_counter_r;
    logic [4:0] month_counter_r;
    logic [7:0] year_counter_r;
    rtcca_pkg::rtcca_byte_t alarm_r [`RTCCA_NUM_FIELDS];
    logic step_pending_r;
    logic time_step_r;
    logic eval_r;
    logic prev_match_r;
    logic alarm_match_flag_r;
    logic [7:0] rdata_r;

    logic day_step;
    logic month_step;
    logic year_step;
    logic [2:0] weekday_nxt;
    logic [4:0] month_nxt;
    logic [7:0] year_nxt;
    logic leap_year;
    logic [`RTCCA_NUM_FIELDS-1:0] alarm_field_disable;
    logic [`RTCCA_NUM_FIELDS-1:0] field_valid;
    logic [`RTCCA_NUM_FIELDS-1:0] field_equal;
    logic [`RTCCA_NUM_FIELDS-1:0] field_ok;
    logic all_match;
    logic wr_hit;

    // Decimal value of a two-digit BCD byte is divisible by four when an even tens
    // digit meets units 0, 4 or 8, or an odd tens digit meets units 2 or 6.
    function automatic logic bcd_div4(input logic [7:0] v);
        logic even_tens;
        even_tens = ~v[4];
        if (even_tens)
        begin
            bcd_div4 = (v[3:0] == 4'h0) || (v[3:0] == 4'h4) || (v[3:0] == 4'h8);
        end
        else
        begin
            bcd_div4 = (v[3:0] == 4'h2) || (v[3:0] == 4'h6);
        end
    endfunction

    // Increment request handling. A tick that lands while the host holds the
    // interface is parked; only one can be parked, so a second tick in the same
    // access is lost. That is why the host must finish each access within 1 s.
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            step_pending_r <= 1'b0;
        end
        else if (I_CE)
        begin
            if (I_ACCESS_BUSY && I_TICK_1HZ)
            begin
                step_pending_r <= 1'b1;
            end
            else if (!I_ACCESS_BUSY)
            begin
                step_pending_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            time_step_r <= 1'b0;
        end
        else if (I_CE)
        begin
            time_step_r <= !I_ACCESS_BUSY && (I_TICK_1HZ || step_pending_r);
        end
    end

    assign O_TIME_STEP = time_step_r;

    // Day carries are only honoured in the cycle of an applied step, so nothing
    // in the calendar moves while an access freezes the counters.
    assign day_step = time_step_r && I_DAY_STEP;
    assign month_step = day_step && I_DAY_WRAP;
    assign year_step = month_step && (month_counter_r == `RTCCA_MONTH_LAST);
    assign wr_hit = I_REG_WR;

    always_comb
    begin
        if (weekday_counter_r >= `RTCCA_WKDAY_LAST)
        begin
            weekday_nxt = 3'h0;
        end
        else
        begin
            weekday_nxt = weekday_counter_r + 3'h1;
        end
    end

    always_comb
    begin
        if (month_counter_r == `RTCCA_MONTH_LAST)
        begin
            month_nxt = `RTCCA_RST_MONTH;
        end
        else if (month_counter_r[3:0] == 4'h9)
        begin
            month_nxt = 5'h10;
        end
        else
        begin
            month_nxt = month_counter_r + 5'h01;
        end
    end

    always_comb
    begin
        if (year_counter_r == `RTCCA_YEAR_LAST)
        begin
            year_nxt = 8'h00;
        end
        else if (year_counter_r[3:0] == 4'h9)
        begin
            year_nxt = {year_counter_r[7:4] + 4'h1, 4'h0};
        end
        else
        begin
            year_nxt = {year_counter_r[7:4], year_counter_r[3:0] + 4'h1};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            weekday_counter_r <= `RTCCA_RST_WEEKDAY;
        end
        else if (I_CE)
        begin
            if (wr_hit && I_REG_ADDR == `RTCCA_ADDR_WEEKDAY)
            begin
                weekday_counter_r <= I_REG_WDATA[`RTCCA_WKDAY_MSB:0];
            end
            else if (day_step)
            begin
                weekday_counter_r <= weekday_nxt;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            month_counter_r <= `RTCCA_RST_MONTH;
        end
        else if (I_CE)
        begin
            if (wr_hit && I_REG_ADDR == `RTCCA_ADDR_MONTH)
            begin
                month_counter_r <= I_REG_WDATA[`RTCCA_MONTH_MSB:0];
            end
            else if (month_step)
            begin
                month_counter_r <= month_nxt;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            year_counter_r <= `RTCCA_RST_YEAR;
        end
        else if (I_CE)
        begin
            if (wr_hit && I_REG_ADDR == `RTCCA_ADDR_YEAR)
            begin
                year_counter_r <= I_REG_WDATA;
            end
            else if (year_step)
            begin
                year_counter_r <= year_nxt;
            end
        end
    end

    // Month length for the day counter; year 00 counts as a leap year too.
    assign leap_year = bcd_div4(year_counter_r);

    always_comb
    begin
        case (month_counter_r)
            `RTCCA_MONTH_FEB: O_MONTH_LAST_DAY = leap_year ? 6'h29 : 6'h28;
            5'h04: O_MONTH_LAST_DAY = 6'h30;
            5'h06: O_MONTH_LAST_DAY = 6'h30;
            5'h09: O_MONTH_LAST_DAY = 6'h30;
            5'h11: O_MONTH_LAST_DAY = 6'h30;
            default: O_MONTH_LAST_DAY = 6'h31;
        endcase
    end

    assign O_WEEKDAY = weekday_counter_r;
    assign O_MONTH = month_counter_r;
    assign O_YEAR = year_counter_r;

    // Alarm registers, field 0 seconds through field 4 weekday.
    genvar gi;
    generate
        for (gi = 0; gi < `RTCCA_NUM_FIELDS; gi = gi + 1)
        begin : g_alarm
            always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
            begin
                if (!I_RESETN)
                begin
                    alarm_r[gi] <= `RTCCA_RST_ALARM;
                end
                else if (I_CE && wr_hit && I_REG_ADDR == `RTCCA_ADDR_ALM_SEC + 8'(gi))
                begin
                    alarm_r[gi] <= I_REG_WDATA;
                end
            end
            assign alarm_field_disable[gi] = alarm_r[gi][`RTCCA_ALM_DIS_BIT];
            assign field_ok[gi] = alarm_field_disable[gi] ||
                (field_valid[gi] && field_equal[gi]);
        end
    endgenerate

    // Field validity; the hour layout follows the one hour-format bit.
    always_comb
    begin
        field_valid[0] = (alarm_r[0][6:4] <= 3'h5) && (alarm_r[0][3:0] <= 4'h9);
        field_valid[1] = (alarm_r[1][6:4] <= 3'h5) && (alarm_r[1][3:0] <= 4'h9);
        if (I_HOUR_12H)
        begin
            field_valid[2] = (alarm_r[2][3:0] <= 4'h9) &&
                ((!alarm_r[2][4] && alarm_r[2][3:0] != 4'h0) ||
                 (alarm_r[2][4] && alarm_r[2][3:0] <= 4'h2));
        end
        else
        begin
            field_valid[2] = (alarm_r[2][3:0] <= 4'h9) && (alarm_r[2][5:4] <= 2'h2) &&
                (alarm_r[2][5:4] != 2'h2 || alarm_r[2][3:0] <= 4'h3);
        end
        field_valid[3] = (alarm_r[3][5:4] <= 2'h3) && (alarm_r[3][3:0] <= 4'h9) &&
            (alarm_r[3][5:0] != 6'h00) && (alarm_r[3][5:0] <= 6'h31);
        field_valid[4] = (alarm_r[4][2:0] <= `RTCCA_WKDAY_LAST);
    end

    always_comb
    begin
        field_equal[0] = (alarm_r[0][6:0] == I_SECONDS);
        field_equal[1] = (alarm_r[1][6:0] == I_MINUTES);
        field_equal[2] = (alarm_r[2][5:0] == I_HOURS);
        field_equal[3] = (alarm_r[3][5:0] == I_DAYS);
        field_equal[4] = (alarm_r[4][2:0] == weekday_counter_r);
    end

    // With every field disabled there is nothing to match, so no alarm fires.
    assign all_match = (&field_ok) && !(&alarm_field_disable);

    // Compare one cycle after a step, once the time counters hold the new value.
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            eval_r <= 1'b0;
        end
        else if (I_CE)
        begin
            eval_r <= time_step_r;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            prev_match_r <= 1'b0;
        end
        else if (I_CE && eval_r)
        begin
            prev_match_r <= all_match;
        end
    end

    // A new match in the same cycle as a clear wins, so no alarm is lost.
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            alarm_match_flag_r <= 1'b0;
        end
        else if (I_CE)
        begin
            if (eval_r && all_match && !prev_match_r)
            begin
                alarm_match_flag_r <= 1'b1;
            end
            else if (I_FLAG_CLEAR)
            begin
                alarm_match_flag_r <= 1'b0;
            end
        end
    end

    assign O_ALARM_FLAG = alarm_match_flag_r;

    // Register read port; unused calendar bits and unmapped addresses read as zero, alarm bytes read back as written.
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            rdata_r <= 8'h00;
        end
        else if (I_CE && I_REG_RD)
        begin
            case (I_REG_ADDR)
                `RTCCA_ADDR_WEEKDAY: rdata_r <= {5'h00, weekday_counter_r};
                `RTCCA_ADDR_MONTH: rdata_r <= {3'h0, month_counter_r};
                `RTCCA_ADDR_YEAR: rdata_r <= year_counter_r;
                `RTCCA_ADDR_ALM_SEC: rdata_r <= alarm_r[0];
                `RTCCA_ADDR_ALM_MIN: rdata_r <= alarm_r[1];
                `RTCCA_ADDR_ALM_HOUR: rdata_r <= alarm_r[2];
                `RTCCA_ADDR_ALM_DAY: rdata_r <= alarm_r[3];
                `RTCCA_ADDR_ALM_WKDAY: rdata_r <= alarm_r[4];
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign O_REG_RDATA = rdata_r;

endmodule

// File: tb/rtcca_properties.sv
`timescale 1ns/1ps
module rtcca_properties (
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    input wire logic I_CE,
    input wire logic I_TICK_1HZ,
    input wire logic I_ACCESS_BUSY,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic I_DAY_STEP,
    input wire logic I_DAY_WRAP,
    input wire logic I_FLAG_CLEAR,
    input wire logic O_TIME_STEP,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic [2:0] O_WEEKDAY,
    input wire logic [4:0] O_MONTH,
    input wire logic [7:0] O_YEAR,
    input wire logic [5:0] O_MONTH_LAST_DAY,
    input wire logic O_ALARM_FLAG
);
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RESETN);
    // A BCD year is a multiple of four when the units fit the parity of the tens.
    wire logic leap = O_YEAR[4] ? (O_YEAR[1:0] == 2'h2) : (O_YEAR[1:0] == 2'h0);
    sequence s_park;
        I_CE && I_ACCESS_BUSY && I_TICK_1HZ ##1 !I_ACCESS_BUSY;
    endsequence
    sequence s_day;
        I_CE && O_TIME_STEP && I_DAY_STEP && !I_REG_WR;
    endsequence
    a_busy_no_step: assert property (I_CE && I_ACCESS_BUSY |=> !O_TIME_STEP)
        else $error("Time step during host access.");
    a_park_release: assert property (s_park |=> O_TIME_STEP)
        else $error("Parked tick not applied after access.");
    a_cal_frozen: assert property (I_CE && !O_TIME_STEP && !I_REG_WR |=>
        $stable(O_WEEKDAY) && $stable(O_MONTH) && $stable(O_YEAR))
        else $error("Calendar moved without a time step.");
    a_weekday_step: assert property (s_day |=> O_WEEKDAY ==
        (($past(O_WEEKDAY) >= 3'h6) ? 3'h0 : $past(O_WEEKDAY) + 3'h1))
        else $error("Weekday step wrong.");
    a_month_wrap: assert property (s_day ##0 I_DAY_WRAP && O_MONTH == 5'h12 |=>
        O_MONTH == 5'h01)
        else $error("Month did not wrap to January.");
    a_year_read: assert property (I_CE && I_REG_RD && !I_REG_WR && I_REG_ADDR == 8'h09
        |=> O_REG_RDATA == $past(O_YEAR))
        else $error("Year read data wrong.");
    a_leap_feb: assert property (O_MONTH == 5'h02 |->
        O_MONTH_LAST_DAY == (leap ? 6'h29 : 6'h28))
        else $error("February length wrong.");
    a_flag_sticky: assert property (O_ALARM_FLAG && !I_FLAG_CLEAR |=> O_ALARM_FLAG)
        else $error("Alarm flag dropped without clear.");
    a_flag_cause: assert property ($rose(O_ALARM_FLAG) |-> $past(O_TIME_STEP, 2))
        else $error("Alarm flag rose without a time step.");
endmodule

bind rtcca_core rtcca_properties u_props (.I_SYS_CLK, .I_RESETN, .I_CE, .I_TICK_1HZ,
    .I_ACCESS_BUSY, .I_REG_ADDR, .I_REG_WR, .I_REG_RD, .I_DAY_STEP, .I_DAY_WRAP,
    .I_FLAG_CLEAR, .O_TIME_STEP, .O_REG_RDATA, .O_WEEKDAY, .O_MONTH, .O_YEAR,
    .O_MONTH_LAST_DAY, .O_ALARM_FLAG);

// File: tb/rtcca_lower.sv
`timescale 1ns/1ps
module rtcca_lower (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_step,
    output logic [6:0] o_secs
);
    // Only steps move the count, so a frozen block also freezes this model.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_secs <= 7'h00;
        else if (i_step)
            o_secs <= (o_secs == 7'h59) ? 7'h00 : (o_secs[3:0] == 4'h9) ?
                {o_secs[6:4] + 3'h1, 4'h0} : o_secs + 7'h01;
    end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, ce, tick, busy, wr, rd, ds, dw, clr, h12, step, flag;
    logic [7:0] addr, wdata, rdata, year;
    logic [6:0] secs, mins;
    logic [5:0] hrs, days, last;
    logic [4:0] month;
    logic [2:0] wkday;
    logic [7:0] rst_val [8] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80};
    logic [7:0] leap_yr [3] = '{8'h96, 8'h98, 8'h00};
    logic [7:0] leap_day [3] = '{8'h29, 8'h28, 8'h29};
    int fails = 0, n_tests = 0, steps = 0, k;
    rtcca_core DUT (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_CE(ce), .I_TICK_1HZ(tick),
        .I_ACCESS_BUSY(busy), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata),
        .I_REG_RD(rd), .I_SECONDS(secs), .I_MINUTES(mins), .I_HOURS(hrs),
        .I_HOUR_12H(h12), .I_DAYS(days), .I_DAY_STEP(ds), .I_DAY_WRAP(dw),
        .I_FLAG_CLEAR(clr), .O_TIME_STEP(step), .O_REG_RDATA(rdata), .O_WEEKDAY(wkday),
        .O_MONTH(month), .O_YEAR(year), .O_MONTH_LAST_DAY(last), .O_ALARM_FLAG(flag));
    rtcca_lower u_lower (.i_clk(clk), .i_rst_n(rst_n), .i_step(step), .o_secs(secs));
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // Counted on the falling edge, where the one-cycle step pulse has settled.
    always @(negedge clk)
        if (step === 1'h1)
            steps++;
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'h1;
        @(negedge clk);
        wr = 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'h1;
        @(negedge clk);
        rd = 1'h0;
        chk($sformatf("reg %h", a), exp, rdata);
    endtask
    // Step, evaluation and flag take three edges; four leaves margin.
    task automatic tick_sec();
        @(negedge clk);
        tick = 1'h1;
        @(negedge clk);
        tick = 1'h0;
        repeat (4) @(negedge clk);
    endtask
    task automatic clear_flag();
        @(negedge clk);
        clr = 1'h1;
        @(negedge clk);
        clr = 1'h0;
    endtask
    task automatic do_reset();
        rst_n = 1'h0;
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
    endtask
    initial
    begin
        #(40 * 3000);
        fails++;
        complete_run();
    end
    initial
    begin
        {tick, busy, wr, rd, ds, dw, clr, h12} = 8'h00;
        ce = 1'h1;
        addr = 8'h00;
        wdata = 8'h00;
        mins = 7'h30;
        hrs = 6'h05;
        days = 6'h01;
        do_reset();
        for (k = 0; k < 8; k++)
            rd_reg(8'h07 + k[7:0], rst_val[k]);
        chk("last day", 8'h31, {2'h0, last});
        wr_reg(8'h0F, 8'h55);
        rd_reg(8'h0F, 8'h00);
        wr_reg(8'h07, 8'hFE);
        rd_reg(8'h07, 8'h06);
        wr_reg(8'h08, 8'hF2);
        rd_reg(8'h08, 8'h12);
        wr_reg(8'h09, 8'h99);
        rd_reg(8'h09, 8'h99);
        ds = 1'h1;
        dw = 1'h1;
        tick_sec();
        ds = 1'h0;
        dw = 1'h0;
        rd_reg(8'h07, 8'h00);
        rd_reg(8'h08, 8'h01);
        rd_reg(8'h09, 8'h00);
        chk("weekday", 8'h00, {5'h0, wkday});
        chk("month", 8'h01, {3'h0, month});
        chk("year", 8'h00, year);
        wr_reg(8'h08, 8'h02);
        for (k = 0; k < 3; k++)
        begin
            wr_reg(8'h09, leap_yr[k]);
            chk("last day", leap_day[k], {2'h0, last});
        end
        k = steps;
        busy = 1'h1;
        tick_sec();
        chk("steps", 8'h00, 8'(steps - k));
        @(negedge clk);
        tick = 1'h1;
        @(negedge clk);
        tick = 1'h0;
        busy = 1'h0;
        repeat (4) @(negedge clk);
        chk("steps", 8'h01, 8'(steps - k));
        // A low clock enable must drop the tick and ignore the write.
        ce = 1'h0;
        tick_sec();
        wr_reg(8'h09, 8'h42);
        ce = 1'h1;
        chk("steps", 8'h01, 8'(steps - k));
        rd_reg(8'h09, 8'h00);
        do_reset();
        wr_reg(8'h0B, 8'h30);
        wr_reg(8'h0C, 8'h87);
        tick_sec();
        chk("flag", 8'h01, {7'h0, flag});
        clear_flag();
        chk("flag", 8'h00, {7'h0, flag});
        tick_sec();
        chk("flag", 8'h00, {7'h0, flag});
        wr_reg(8'h0C, 8'h25);
        h12 = 1'h1;
        hrs = 6'h25;
        mins = 7'h31;
        tick_sec();
        chk("flag", 8'h00, {7'h0, flag});
        mins = 7'h30;
        tick_sec();
        tick_sec();
        chk("flag", 8'h01, {7'h0, flag});
        clear_flag();
        wr_reg(8'h0D, 8'h35);
        days = 6'h35;
        mins = 7'h31;
        tick_sec();
        mins = 7'h30;
        tick_sec();
        chk("flag", 8'h00, {7'h0, flag});
        wr_reg(8'h0D, 8'h80);
        wr_reg(8'h0E, 8'h00);
        tick_sec();
        chk("flag", 8'h01, {7'h0, flag});
        clear_flag();
        h12 = 1'h0;
        hrs = 6'h23;
        wr_reg(8'h0C, 8'h23);
        mins = 7'h31;
        tick_sec();
        mins = 7'h30;
        tick_sec();
        chk("flag", 8'h01, {7'h0, flag});
        complete_run();
    end
endmodule
